// file: rtl/tcc_pkg.sv
// tcc_pkg: register map, field layout and timing constants of the temperature compensation block
package tcc_pkg;

  // register offsets
  localparam logic [7:0] TCC_OFF_TEMP_LOW  = 8'h28;
  localparam logic [7:0] TCC_OFF_TEMP_HIGH = 8'h29;
  localparam logic [7:0] TCC_OFF_TURNOVER  = 8'h2c;
  localparam logic [7:0] TCC_OFF_HOT_CURV  = 8'h2d;
  localparam logic [7:0] TCC_OFF_NET_LOW   = 8'h2e;
  localparam logic [7:0] TCC_OFF_NET_HIGH  = 8'h2f;
  localparam logic [7:0] TCC_OFF_CTRL      = 8'h2a;
  localparam logic [7:0] TCC_OFF_COLD_CURV = 8'h2b;
  localparam logic [7:0] TCC_OFF_TRIM      = 8'h0c;
  localparam logic [7:0] TCC_OFF_GAIN      = 8'h0d;

  // field positions
  localparam int TCC_CTRL_TSE_BIT   = 0;
  localparam int TCC_TURN_DIR_BIT   = 4;
  localparam int TCC_CODE_W         = 10;
  localparam int TCC_TURN_W         = 5;
  localparam int TCC_CURV_W         = 7;
  localparam int TCC_GAIN_W         = 5;
  localparam int TCC_NET_W          = 16;

  // reset / preset values
  localparam logic [7:0] TCC_TURNOVER_RST = 8'h00;
  localparam logic [7:0] TCC_CTRL_RST     = 8'h00;
  localparam logic [9:0] TCC_CODE_RST     = 10'h000;

  // arithmetic constants
  localparam logic [9:0]  TCC_TURN_BASE   = 10'd596;
  localparam logic [9:0]  TCC_KELVIN_OFS  = 10'd273;
  localparam logic [9:0]  TCC_CODE_MIN    = 10'd446;
  localparam logic [9:0]  TCC_CODE_MAX    = 10'd726;
  localparam int          TCC_CURV_SHIFT  = 12;   // divide by 4096
  localparam int          TCC_CURV_SCALE  = 2048;
  localparam logic [4:0]  TCC_TRIM_BIAS   = 5'd16;

  // timing: one conversion every 1 ms at 25 MHz
  localparam int TCC_CLK_HZ       = 25000000;
  localparam int TCC_CONV_US      = 1000;
  localparam int TCC_CONV_CYCLES  = TCC_CLK_HZ / 1000000 * TCC_CONV_US;

  typedef enum logic [1:0] {
    TCC_IDLE,
    TCC_FIRST,
    TCC_SECOND,
    TCC_CALC
  } tcc_state_type;

endpackage : tcc_pkg

// file: rtl/tcc_sync.sv
// tcc_sync: two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
`default_nettype none
module tcc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : tcc_sync
`default_nettype wire

// file: rtl/tcc_curv.sv
// tcc_curv: curvature term coefficient * (t - t0)^2 / 4096
`timescale 1ns/1ps
`default_nettype none
module tcc_curv (
  // operands
  input  wire logic [9:0]  code,
  input  wire logic [9:0]  turn_ref,
  input  wire logic [6:0]  coef,
  // result
  output var  logic [15:0] curv
);
  import tcc_pkg::*;

  logic [9:0]  diff;
  logic [19:0] square;
  logic [26:0] prod;

  assign diff   = (code >= turn_ref) ? code - turn_ref : turn_ref - code;
  assign square = diff * diff;
  assign prod   = square * coef;
  // the quotient never needs more than 15 bits, so it cannot overflow
  assign curv   = {1'b0, prod[26:TCC_CURV_SHIFT]};
endmodule : tcc_curv
`default_nettype wire

// file: rtl/tcc_top.sv
// tcc_top: temperature readout and oscillator compensation arithmetic
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - ten-bit code split over two byte registers
// - code averages two consecutive sensor conversions
// - code equals twice absolute temperature kelvin
// - convert only while sense enable set
// - practical code range 446 to 726
// - net correction is initial plus curvature
// - initial term from trim and gain
// - curvature is coefficient times square over 4096
// - turnover reference is 596 plus field
// - pick cold or hot coefficient by code
// - coefficients unsigned, scaled by 2048
// - turnover register 2Ch, five bits, read-only
// - turnover field sign-magnitude half-degree steps
// - hot coefficient seven bits at 2Dh, read-only
// - hot coefficient applies above turnover
// - initial term equals twice gain*analog minus digital-16
// - gain register five bits, loaded at power-up
module tcc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // temperature converter sample from the analog front end
  input  wire logic [9:0]  sense_code,
  input  wire logic        sense_valid,
  // production presets recalled at power-up
  input  wire logic [4:0]  preset_turnover,
  input  wire logic [6:0]  preset_hot_curv,
  input  wire logic [6:0]  preset_cold_curv,
  input  wire logic [4:0]  preset_trim_gain,
  input  wire logic [7:0]  preset_initial_trim,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  // results
  output var  logic [9:0]  temp_code,
  output var  logic [15:0] net_correction,
  output var  logic        net_valid
);
  import tcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [9:0]  code_s;
  logic        valid_s;
  logic [4:0]  turn_s;
  logic [6:0]  hot_s;
  logic [6:0]  cold_s;
  logic [4:0]  gain_s;
  logic [7:0]  trim_s;

  tcc_sync #(.W(11)) u_sync_sense (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({sense_valid, sense_code}),
    .q      ({valid_s, code_s})
  );

  tcc_sync #(.W(32)) u_sync_preset (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({preset_turnover, preset_hot_curv, preset_cold_curv,
              preset_trim_gain, preset_initial_trim}),
    .q      ({turn_s, hot_s, cold_s, gain_s, trim_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // power-up recall of presets, caught once after reset release
  logic        recalled_r;
  logic [4:0]  turn_r;
  logic [6:0]  hot_r;
  logic [6:0]  cold_r;
  logic [4:0]  gain_r;
  logic [7:0]  trim_r;
  logic [1:0]  settle_r;
  logic        settle_done;
  logic        recall_now;

  // presets are read only after the synchroniser has flushed reset zeros
  assign settle_done = (settle_r == 2'h3);
  assign recall_now  = !recalled_r && settle_done;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_r <= 2'h0;
    end else if (!settle_done) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      recalled_r <= 1'b0;
      turn_r     <= TCC_TURNOVER_RST[4:0];
      hot_r      <= 7'h00;
      cold_r     <= 7'h00;
      gain_r     <= 5'h00;
      trim_r     <= 8'h00;
    end else if (recall_now) begin
      recalled_r <= 1'b1;
      turn_r     <= turn_s;
      hot_r      <= hot_s;
      cold_r     <= cold_s;
      gain_r     <= gain_s;
      trim_r     <= trim_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: only the sense enable is writable
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_wdata;
  logic       ctrl_wr;
  logic       temp_sense_enable;

  assign ctrl_wr    = reg_wr && (reg_addr == TCC_OFF_CTRL);
  assign ctrl_wdata = {7'h00, reg_wdata[TCC_CTRL_TSE_BIT]};
  assign temp_sense_enable        = ctrl_r[TCC_CTRL_TSE_BIT];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= TCC_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= ctrl_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // averaging sequencer: two conversions, then recompute
  tcc_state_type state_r;
  tcc_state_type state_nxt;
  logic [9:0]    first_r;
  logic [9:0]    code_r;
  logic [10:0]   sum;
  logic [9:0]    avg;
  logic          take;
  logic          load_first;
  logic          load_second;
  logic          calc_now;

  assign take        = valid_s && temp_sense_enable;
  assign sum         = {1'b0, first_r} + {1'b0, code_s};
  // code is twice kelvin; rounded mean of two samples
  assign avg         = 10'((sum + 11'd1) >> 1);
  assign load_first  = (state_r == TCC_FIRST) && take;
  assign load_second = (state_r == TCC_SECOND) && take;
  assign calc_now    = (state_r == TCC_CALC);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TCC_IDLE:   if (temp_sense_enable && recalled_r) state_nxt = TCC_FIRST;
      TCC_FIRST:  if (!temp_sense_enable) state_nxt = TCC_IDLE;
                  else if (take) state_nxt = TCC_SECOND;
      TCC_SECOND: if (!temp_sense_enable) state_nxt = TCC_IDLE;
                  else if (take) state_nxt = TCC_CALC;
      TCC_CALC:   state_nxt = temp_sense_enable ? TCC_FIRST : TCC_IDLE;
      default:    state_nxt = TCC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= TCC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_r <= TCC_CODE_RST;
    end else if (load_first) begin
      first_r <= code_s;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_r <= TCC_CODE_RST;
    end else if (load_second) begin
      code_r <= avg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compensation arithmetic
  logic [9:0]  turn_ref;
  logic        above;
  logic [6:0]  coef;
  logic [15:0] curv_corr;
  logic signed [15:0] init_corr;
  logic signed [15:0] net_sum;
  logic        in_range;
  logic        turn_below;
  logic [9:0]  turn_steps;

  // sign-magnitude half-degree steps, both zero patterns give 596
  assign turn_below = turn_r[TCC_TURN_DIR_BIT];
  assign turn_steps = {6'h00, turn_r[3:0]};
  assign turn_ref   = turn_below ? TCC_TURN_BASE - turn_steps
                                 : TCC_TURN_BASE + turn_steps;
  assign above    = code_r >= turn_ref;
  assign coef     = above ? hot_r : cold_r;
  assign in_range = (code_r >= TCC_CODE_MIN) && (code_r <= TCC_CODE_MAX);

  tcc_curv u_curv (
    .code     (code_r),
    .turn_ref (turn_ref),
    .coef     (coef),
    .curv     (curv_corr)
  );

  // initial term: 2*(gain*analog_trim - (digital_trim-16)); trim byte packs
  // analog trim in the top three bits and digital trim in the low five bits
  logic [4:0]         analog_trim_value;
  logic [4:0]         digital_trim_value;
  logic [9:0]         gain_prod;
  logic signed [15:0] gain_term;
  logic signed [15:0] digital_term;
  logic signed [15:0] bias_term;

  assign analog_trim_value  = {2'b00, trim_r[7:5]};
  assign digital_trim_value = trim_r[4:0];
  assign gain_prod          = 10'(gain_r * analog_trim_value);
  assign gain_term          = 16'(signed'({1'b0, gain_prod, 1'b0}));
  assign digital_term       = 16'(signed'({1'b0, digital_trim_value, 1'b0}));
  assign bias_term          = 16'(signed'({1'b0, TCC_TRIM_BIAS, 1'b0}));
  assign init_corr          = gain_term - digital_term + bias_term;
  assign net_sum   = init_corr + signed'(curv_corr);

  // all three results move together, once per averaged pair
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      net_correction <= 16'h0000;
    end else if (calc_now) begin
      net_correction <= net_sum;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      net_valid <= 1'b0;
    end else if (calc_now) begin
      net_valid <= in_range;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_code <= TCC_CODE_RST;
    end else if (calc_now) begin
      temp_code <= code_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux; presets ignore writes
  logic [7:0] rd_mux;
  logic       sel_temp_low;
  logic       sel_temp_high;
  logic       sel_turnover;
  logic       sel_hot;
  logic       sel_cold;
  logic       sel_gain;
  logic       sel_trim;
  logic       sel_ctrl;
  logic       sel_net_low;
  logic       sel_net_high;

  assign sel_temp_low  = (reg_addr == TCC_OFF_TEMP_LOW);
  assign sel_temp_high = (reg_addr == TCC_OFF_TEMP_HIGH);
  assign sel_turnover  = (reg_addr == TCC_OFF_TURNOVER);
  assign sel_hot       = (reg_addr == TCC_OFF_HOT_CURV);
  assign sel_cold      = (reg_addr == TCC_OFF_COLD_CURV);
  assign sel_gain      = (reg_addr == TCC_OFF_GAIN);
  assign sel_trim      = (reg_addr == TCC_OFF_TRIM);
  assign sel_ctrl      = (reg_addr == TCC_OFF_CTRL);
  assign sel_net_low   = (reg_addr == TCC_OFF_NET_LOW);
  assign sel_net_high  = (reg_addr == TCC_OFF_NET_HIGH);

  // one-hot address decode, so the or of masked fields is a plain mux;
  // an unmapped address selects nothing and reads zero
  assign rd_mux = ({8{sel_temp_low}}  & temp_code[7:0])
                | ({8{sel_temp_high}} & {6'h00, temp_code[9:8]})
                | ({8{sel_turnover}}  & {3'h0, turn_r})
                | ({8{sel_hot}}       & {1'b0, hot_r})
                | ({8{sel_cold}}      & {1'b0, cold_r})
                | ({8{sel_gain}}      & {3'h0, gain_r})
                | ({8{sel_trim}}      & trim_r)
                | ({8{sel_ctrl}}      & ctrl_r)
                | ({8{sel_net_low}}   & net_correction[7:0])
                | ({8{sel_net_high}}  & net_correction[15:8]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule : tcc_top
`default_nettype wire

// file: tb/tcc_chk.sv
// tcc_chk: port-level assertions for the compensation block
`timescale 1ns/1ps
`default_nettype none
module tcc_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // watched inputs
  input wire logic        sense_valid,
  input wire logic [4:0]  preset_turnover,
  input wire logic [6:0]  preset_hot_curv,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  // watched outputs
  input wire logic [7:0]  reg_rdata,
  input wire logic [9:0]  temp_code,
  input wire logic [15:0] net_correction,
  input wire logic        net_valid
);
  import tcc_pkg::*;
  logic [3:0] up_r;
  logic [3:0] quiet_r;
  wire  [7:0] code_lo = temp_code[7:0];
  wire  [1:0] code_hi = temp_code[9:8];
  // cycles since reset release and since the last sample pulse, both saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_r    <= 4'h0;
      quiet_r <= 4'hf;
    end else begin
      up_r    <= (up_r == 4'hf) ? up_r : up_r + 4'h1;
      quiet_r <= sense_valid ? 4'h0 : ((quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  rd_low_a: assert property (rd_at(TCC_OFF_TEMP_LOW) |=> reg_rdata == $past(code_lo))
    else $error("low code byte wrong");
  rd_high_a: assert property (rd_at(TCC_OFF_TEMP_HIGH) |=> reg_rdata == {6'h00, $past(code_hi)})
    else $error("high code byte wrong");
  turn_rd_a: assert property (up_r == 4'hf ##0 rd_at(TCC_OFF_TURNOVER)
    |=> reg_rdata == {3'h0, preset_turnover}) else $error("turnover read wrong");
  hot_rd_a: assert property (up_r == 4'hf ##0 rd_at(TCC_OFF_HOT_CURV)
    |=> reg_rdata[6:0] == preset_hot_curv) else $error("hot coefficient read wrong");
  unmap_rd_a: assert property (rd_at(8'h40) |=> reg_rdata == 8'h00) else $error("unmapped read");
  code_range_a: assert property (net_valid == (temp_code >= TCC_CODE_MIN && temp_code <= TCC_CODE_MAX))
    else $error("valid flag disagrees with code");
  code_upd_a: assert property ($changed(temp_code) |-> quiet_r < 4'hc)
    else $error("code moved without samples");
  net_upd_a: assert property ($changed(net_correction) |-> quiet_r < 4'hc)
    else $error("net moved without samples");
endmodule : tcc_chk
bind tcc_top tcc_chk u_chk (.clk(clk), .arst_n(arst_n), .sense_valid(sense_valid),
  .preset_turnover(preset_turnover), .preset_hot_curv(preset_hot_curv), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_code(temp_code),
  .net_correction(net_correction), .net_valid(net_valid));
`default_nettype wire

// file: tb/tcc_top_tb.sv
// tcc_top_tb: self-checking bench for the compensation block
`timescale 1ns/1ps
`default_nettype none
module tcc_top_tb;
  import tcc_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [9:0]  sc = 10'h000;
  logic        sv = 1'b0;
  logic [4:0]  tov = 5'h13;
  logic [6:0]  hot = 7'h46;
  logic [6:0]  cold = 7'h30;
  logic [4:0]  gain = 5'h0c;
  logic [7:0]  trim = 8'h4a;
  logic [7:0]  ra = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  wire  [7:0]  rdat;
  wire  [9:0]  code;
  wire  [15:0] net;
  wire         nv;
  int          error_cnt = 0;
  int          num_checks = 0;
  logic [7:0]  d;
  logic [7:0]  d2;
  tcc_top uut (.clk(clk), .arst_n(arst_n), .sense_code(sc), .sense_valid(sv),
    .preset_turnover(tov), .preset_hot_curv(hot), .preset_cold_curv(cold),
    .preset_trim_gain(gain), .preset_initial_trim(trim), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .temp_code(code),
    .net_correction(net), .net_valid(nv));
  always #20 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rreg(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    q = rdat;
  endtask : rreg
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    ra <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic samp(input logic [9:0] c);
    @(posedge clk);
    sc <= c;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : samp
  function automatic logic [15:0] exp_net(input logic [9:0] t);
    int t0;
    int df;
    int cv;
    t0 = tov[4] ? 596 - int'(tov[3:0]) : 596 + int'(tov[3:0]);
    df = int'(t) - t0;
    cv = ((int'(t) >= t0 ? int'(hot) : int'(cold)) * df * df) >>> 12;
    if (cv > 32'h7fff) cv = 32'h7fff;
    return 16'(2 * (int'(gain) * int'(trim[7:5]) - (int'(trim[4:0]) - 16)) + cv);
  endfunction : exp_net
  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // presets read back and survive writes
  task automatic t_presets;
    rreg(TCC_OFF_TURNOVER, d);
    wreg(TCC_OFF_TURNOVER, 8'hff);
    rreg(TCC_OFF_TURNOVER, d2);
    chk(d, {3'h0, tov});
    chk(d2, {3'h0, tov});
    wreg(TCC_OFF_HOT_CURV, 8'h00);
    rreg(TCC_OFF_HOT_CURV, d);
    chk(d[6:0], hot);
    rreg(TCC_OFF_GAIN, d);
    chk(d, {3'h0, gain});
    rreg(TCC_OFF_TRIM, d);
    chk(d, trim);
    rreg(TCC_OFF_COLD_CURV, d);
    chk(d, {1'b0, cold});
    rreg(8'h40, d);
    chk(d, 8'h00);
  endtask : t_presets
  // samples ignored while sensing is off
  task automatic t_off;
    samp(10'd600);
    samp(10'd610);
    repeat (20) @(posedge clk);
    chk(code, 10'h000);
  endtask : t_off
  // a half pair is dropped when sensing is switched off
  task automatic t_discard;
    wreg(TCC_OFF_CTRL, 8'h01);
    rreg(TCC_OFF_CTRL, d);
    chk(d, 8'h01);
    samp(10'd500);
    wreg(TCC_OFF_CTRL, 8'h00);
    wreg(TCC_OFF_CTRL, 8'h01);
    chk(code, 10'h000);
  endtask : t_discard
  task automatic t_conv(input logic [9:0] a, input logic [9:0] b);
    logic [9:0] e;
    e = 10'((11'(a) + 11'(b) + 11'd1) >> 1);
    samp(a);
    samp(b);
    for (int i = 0; i < 20 && code !== e; i++) @(posedge clk);
    @(posedge clk);
    chk(code, e);
    chk(net, exp_net(e));
    chk(nv, e >= 10'd446 && e <= 10'd726);
    rreg(TCC_OFF_TEMP_LOW, d);
    rreg(TCC_OFF_TEMP_HIGH, d2);
    chk({d2, d}, {6'h00, e});
    rreg(TCC_OFF_NET_LOW, d);
    rreg(TCC_OFF_NET_HIGH, d2);
    chk({d2, d}, exp_net(e));
  endtask : t_conv
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_presets();
    t_off();
    t_discard();
    t_conv(10'd600, 10'd603);
    t_conv(10'd700, 10'd701);
    t_conv(10'd450, 10'd451);
    t_conv(10'd593, 10'd593);
    t_conv(10'd446, 10'd446);
    t_conv(10'd726, 10'd727);
    t_conv(10'd800, 10'd800);
    summarize();
  end
  initial begin
    #1ms;
    error_cnt++;
    summarize();
  end
endmodule : tcc_top_tb
`default_nettype wire
